// File: hw/cs_dev_pkg.sv
// Constants, state encoding and state record of the chip-select device interface.
// Contract
// - Type 3 regions: OE asserted at least one cycle after chip enable.
// - Type 9 regions take the next chip enable one cycle earlier than type 3; the code takes it two cycles earlier, skipping HOLD and IDLE.
// - Type 1 burst uses OE and WE plus a burst beat request signal.
// - Type 2 burst: chip enable held through latency; start strobe timed like TS.
// - Type 2 burst regions use internal acknowledge; controller generates transfer acknowledge.
// - One shared pin: select 1 gives last-beat timing, 0 beat request timing; code gives beat request outside type 2, last-beat in type 2 if 1.
// - Burst regions latch address; next access to same device may overlap.
// - Codes 0101 type 1 async OE, 0111 type 1 sync OE, 1000 type 2.
// - Single-word access to burstable region asserts OE or WE one word only.
// - Fixed burst keeps OE or WE asserted four beats unless terminated early.
// - Burst to non-burstable region: signal burst inhibit, do a single transfer.
// - Burst to 16-bit burstable port: hold enables until bus unit ends burst.
// - Single word to 16-bit port: one access and report 16-bit width.
// - Config bit 0 selects shared pins: 0 address, 1 chip-select (default).
// - Config bit 2 selects burst type: 0 type 1 default, 1 type 2; CFG_DEFAULT sets bit 2 to 1.
// - Config bit 3 boot type 0x08 or 0x01; bit 4 boot width 16 or 32.
// - Config bits 6 to 8 give boot acknowledge delay 0 to 7 waits.
// - Boot region: CE and OE only, no WE; select over 64 Mbyte; base by prefix.
// - During reset all chip-select outputs are driven high.
package cs_dev_pkg;
	localparam logic [3:0] TYPE_ASYNC = 4'h1;
	localparam logic [3:0] TYPE_SYNC_ASYNC_OE = 4'h2;
	localparam logic [3:0] TYPE_SYNC_OE = 4'h3;
	localparam logic [3:0] TYPE_BURST1_ASYNC_OE = 4'h5;
	localparam logic [3:0] TYPE_BURST1_SYNC_OE = 4'h7;
	localparam logic [3:0] TYPE_BURST2 = 4'h8;
	localparam logic [3:0] TYPE_EARLY_OVERLAP = 4'h9;
	localparam logic [2:0] BURST_BEATS = 3'h4;
	localparam logic [2:0] SINGLE_BEAT = 3'h1;
	localparam int CFG_WIDTH = 9;
	localparam int CFG_PIN_FUNCTION = 0;
	localparam int CFG_VECTOR_PREFIX = 1;
	localparam int CFG_BURST_TYPE = 2;
	localparam int CFG_BOOT_TYPE = 3;
	localparam int CFG_BOOT_WIDTH = 4;
	localparam int CFG_BOOT_WAIT_LSB = 6;
	localparam logic [8:0] CFG_DEFAULT = 9'h1DD;
	localparam logic [3:0] BOOT_TYPE_BURST = 4'h8;
	localparam logic [3:0] BOOT_TYPE_ASYNC = 4'h1;
	localparam logic [31:0] BOOT_BASE_HIGH = 32'hFFF00000;
	localparam logic [31:0] BOOT_BASE_LOW = 32'h00000000;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_LEAD = 5'h02,
		ST_WAIT = 5'h04,
		ST_DATA = 5'h08,
		ST_HOLD = 5'h10
	} state_t;

	typedef struct packed {
		state_t state;
		logic [8:0] cfg;
		logic [3:0] interface_type;
		logic isWrite;
		logic isBoot;
		logic ackInternal;
		logic port16;
		logic holdToEnd;
		logic [2:0] waitStates;
		logic [2:0] waitCnt;
		logic [2:0] beats;
		logic chipEnableN;
		logic outputEnableN;
		logic writeEnableN;
		logic burstPinN;
		logic startStrobeN;
		logic bootSelectN;
		logic transferAcknowledge;
		logic burstInhibit;
		logic port16Indicate;
	} cs_state_t;
endpackage : cs_dev_pkg

// File: hw/chip_select_device_interface.sv
// Chip-select sequencer for synchronous and burst external memory regions.
`timescale 1ns/1ps
`default_nettype none
module chip_select_device_interface (
	input wire logic clk,
	input wire logic rst,
	input wire logic clkEn,
	input wire logic [8:0] resetConfig,
	input wire logic transferStart,
	input wire logic accessWrite,
	input wire logic accessBurst,
	input wire logic regionHit,
	input wire logic bootHit,
	input wire logic [3:0] interfaceType,
	input wire logic internalAckSelect,
	input wire logic [2:0] regionWaitStates,
	input wire logic regionPort16,
	input wire logic externalAck,
	input wire logic earlyTerminate,
	input wire logic burstEnd,
	output logic chipEnableN,
	output logic outputEnableN,
	output logic writeEnableN,
	output logic burstPinN,
	output logic startStrobeN,
	output logic bootRegionSelectN,
	output logic transferAcknowledge,
	output logic burstInhibit,
	output logic port16Indicate,
	output logic chipSelectPinMode,
	output logic burstPinSelect,
	output logic [31:0] bootRegionBase
);
	cs_dev_pkg::cs_state_t st;
	cs_dev_pkg::cs_state_t next_st;

	logic [3:0] reqType;
	logic [2:0] reqWait;
	logic reqPort16;
	logic reqAckInt;
	logic reqBurstable;
	logic reqSyncOe;
	logic acceptNew;
	logic lastBeat;
	logic beatDone;
	logic overlapOk;

	// Boot accesses take their attributes from the configuration word, not the region ports.
	always_comb begin
		if (bootHit) begin
			reqType = st.cfg[cs_dev_pkg::CFG_BOOT_TYPE] ? cs_dev_pkg::BOOT_TYPE_ASYNC
				: cs_dev_pkg::BOOT_TYPE_BURST;
			reqPort16 = !st.cfg[cs_dev_pkg::CFG_BOOT_WIDTH];
			reqWait = st.cfg[cs_dev_pkg::CFG_BOOT_WAIT_LSB +: 3];
			reqAckInt = 1'b1;
		end else begin
			reqType = interfaceType;
			reqPort16 = regionPort16;
			reqWait = regionWaitStates;
			reqAckInt = internalAckSelect || (interfaceType == cs_dev_pkg::TYPE_BURST2);
		end
		reqBurstable = (reqType == cs_dev_pkg::TYPE_BURST1_ASYNC_OE)
			|| (reqType == cs_dev_pkg::TYPE_BURST1_SYNC_OE)
			|| (reqType == cs_dev_pkg::TYPE_BURST2);
		reqSyncOe = (reqType == cs_dev_pkg::TYPE_SYNC_OE) || (reqType == cs_dev_pkg::TYPE_EARLY_OVERLAP)
			|| (reqType == cs_dev_pkg::TYPE_BURST1_SYNC_OE);
	end

	assign lastBeat = (st.beats == cs_dev_pkg::SINGLE_BEAT) && !st.holdToEnd;
	assign beatDone = st.ackInternal || externalAck;
	// Early overlap only after a type 9 access with acknowledge known internally, when the next request is a read.
	assign overlapOk = (st.interface_type == cs_dev_pkg::TYPE_EARLY_OVERLAP) && st.ackInternal
		&& !accessWrite && (regionHit || bootHit);
	assign acceptNew = transferStart && (regionHit || bootHit);

	function automatic cs_dev_pkg::cs_state_t start_access(input cs_dev_pkg::cs_state_t cur,
		input logic [3:0] t, input logic [2:0] w, input logic p16, input logic ai, input logic burstable,
		input logic syncOe);
		cs_dev_pkg::cs_state_t s;
		s = cur;
		s.state = cs_dev_pkg::ST_LEAD;
		s.interface_type = t;
		s.isWrite = accessWrite && !bootHit;
		s.isBoot = bootHit;
		s.ackInternal = ai;
		s.port16 = p16;
		s.waitStates = w;
		s.waitCnt = w;
		s.holdToEnd = accessBurst && burstable && p16;
		s.beats = (accessBurst && burstable) ? cs_dev_pkg::BURST_BEATS : cs_dev_pkg::SINGLE_BEAT;
		s.burstInhibit = accessBurst && !burstable;
		s.port16Indicate = p16 && !(accessBurst && burstable);
		s.chipEnableN = bootHit;
		s.bootSelectN = !bootHit;
		s.startStrobeN = (t != cs_dev_pkg::TYPE_BURST2);
		s.outputEnableN = accessWrite || syncOe || (t == cs_dev_pkg::TYPE_BURST2);
		s.writeEnableN = 1'b1;
		s.transferAcknowledge = 1'b0;
		s.burstPinN = 1'b1;
		return s;
	endfunction : start_access

	always_comb begin
		next_st = st;
		next_st.startStrobeN = 1'b1;
		next_st.burstInhibit = 1'b0;
		next_st.port16Indicate = 1'b0;
		next_st.transferAcknowledge = 1'b0;
		case (st.state)
			cs_dev_pkg::ST_IDLE: begin
				if (acceptNew) begin
					next_st = start_access(st, reqType, reqWait, reqPort16, reqAckInt, reqBurstable, reqSyncOe);
				end
			end
			cs_dev_pkg::ST_LEAD: begin
				// A synchronous OE goes out only here, a full cycle behind chip enable.
				if (!st.isWrite) begin
					next_st.outputEnableN = (st.interface_type == cs_dev_pkg::TYPE_BURST2);
				end
				next_st.state = (st.waitCnt == 3'h0) ? cs_dev_pkg::ST_DATA : cs_dev_pkg::ST_WAIT;
				if (st.waitCnt == 3'h0) begin
					next_st.writeEnableN = !st.isWrite;
					next_st.transferAcknowledge = st.ackInternal;
					next_st.burstPinN = !((st.interface_type != cs_dev_pkg::TYPE_BURST2) ? !lastBeat
						: (st.cfg[cs_dev_pkg::CFG_BURST_TYPE] && lastBeat));
				end
			end
			cs_dev_pkg::ST_WAIT: begin
				// Chip enable, or the boot select on a boot access, stays low through every wait state.
				next_st.waitCnt = st.waitCnt - 3'h1;
				if (st.waitCnt == 3'h1) begin
					next_st.state = cs_dev_pkg::ST_DATA;
					next_st.writeEnableN = !st.isWrite;
					next_st.transferAcknowledge = st.ackInternal;
					next_st.burstPinN = !((st.interface_type != cs_dev_pkg::TYPE_BURST2) ? !lastBeat
						: (st.cfg[cs_dev_pkg::CFG_BURST_TYPE] && lastBeat));
				end
			end
			cs_dev_pkg::ST_DATA: begin
				if (beatDone) begin
					if (st.holdToEnd) begin
						next_st.transferAcknowledge = st.ackInternal;
						if (burstEnd || earlyTerminate) begin
							next_st.state = cs_dev_pkg::ST_HOLD;
							next_st.transferAcknowledge = 1'b0;
						end
					end else if (lastBeat || earlyTerminate) begin
						next_st.state = cs_dev_pkg::ST_HOLD;
						if (overlapOk && transferStart) begin
							next_st = start_access(st, reqType, reqWait, reqPort16, reqAckInt, reqBurstable,
								reqSyncOe);
						end
					end else begin
						next_st.beats = st.beats - 3'h1;
						next_st.transferAcknowledge = st.ackInternal;
						next_st.burstPinN = !((st.interface_type != cs_dev_pkg::TYPE_BURST2)
							? (st.beats > 3'h2)
							: (st.cfg[cs_dev_pkg::CFG_BURST_TYPE] && (st.beats == 3'h2)));
					end
				end
				if (next_st.state == cs_dev_pkg::ST_HOLD) begin
					next_st.outputEnableN = 1'b1;
					next_st.writeEnableN = 1'b1;
					next_st.burstPinN = 1'b1;
					next_st.chipEnableN = 1'b1;
					next_st.bootSelectN = 1'b1;
				end
			end
			cs_dev_pkg::ST_HOLD: begin
				// One idle cycle lets a device that floats late release the data bus.
				next_st.state = cs_dev_pkg::ST_IDLE;
			end
			default: begin
				next_st.state = cs_dev_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			st.state <= cs_dev_pkg::ST_IDLE;
			// Strap level is taken on every reset cycle, so the last one before release holds.
			st.cfg <= resetConfig;
			st.interface_type <= cs_dev_pkg::TYPE_ASYNC;
			st.isWrite <= 1'b0;
			st.isBoot <= 1'b0;
			st.ackInternal <= 1'b0;
			st.port16 <= 1'b0;
			st.holdToEnd <= 1'b0;
			st.waitStates <= 3'h0;
			st.waitCnt <= 3'h0;
			st.beats <= 3'h0;
			st.chipEnableN <= 1'b1;
			st.outputEnableN <= 1'b1;
			st.writeEnableN <= 1'b1;
			st.burstPinN <= 1'b1;
			st.startStrobeN <= 1'b1;
			st.bootSelectN <= 1'b1;
			st.transferAcknowledge <= 1'b0;
			st.burstInhibit <= 1'b0;
			st.port16Indicate <= 1'b0;
		end else if (clkEn) begin
			st <= next_st;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			chipSelectPinMode <= 1'b1;
			burstPinSelect <= 1'b0;
			bootRegionBase <= cs_dev_pkg::BOOT_BASE_LOW;
		end else if (clkEn) begin
			chipSelectPinMode <= st.cfg[cs_dev_pkg::CFG_PIN_FUNCTION];
			burstPinSelect <= st.cfg[cs_dev_pkg::CFG_BURST_TYPE];
			bootRegionBase <= st.cfg[cs_dev_pkg::CFG_VECTOR_PREFIX] ? cs_dev_pkg::BOOT_BASE_HIGH
				: cs_dev_pkg::BOOT_BASE_LOW;
		end
	end

	assign chipEnableN = st.chipEnableN;
	assign outputEnableN = st.outputEnableN;
	assign writeEnableN = st.writeEnableN;
	assign burstPinN = st.burstPinN;
	assign startStrobeN = st.startStrobeN;
	assign bootRegionSelectN = st.bootSelectN;
	assign transferAcknowledge = st.transferAcknowledge;
	assign burstInhibit = st.burstInhibit;
	assign port16Indicate = st.port16Indicate;

	logic [2:0] ackCount;
	always_ff @(posedge clk) begin
		if (rst || st.state == cs_dev_pkg::ST_IDLE) begin
			ackCount <= 3'h0;
		end else if (clkEn && transferAcknowledge && ackCount != 3'h7) begin
			ackCount <= ackCount + 3'h1;
		end
	end

	a_reset_cs_high: assert property (@(posedge clk) $past(rst) |-> chipEnableN && bootRegionSelectN)
		else $error("chip selects not negated after reset");
	a_sync_oe_lag: assert property (@(posedge clk) disable iff (rst)
		$fell(outputEnableN) && st.interface_type == cs_dev_pkg::TYPE_SYNC_OE |-> $past(!chipEnableN))
		else $error("synchronous OE asserted without a prior chip enable cycle");
	a_burst_beats: assert property (@(posedge clk) disable iff (rst)
		!st.holdToEnd |-> ackCount <= cs_dev_pkg::BURST_BEATS)
		else $error("more than four beats acknowledged");
	a_boot_no_write: assert property (@(posedge clk) disable iff (rst)
		!bootRegionSelectN |-> writeEnableN)
		else $error("write enable asserted on boot region");
	a_strobe_type2: assert property (@(posedge clk) disable iff (rst)
		!startStrobeN |-> st.interface_type == cs_dev_pkg::TYPE_BURST2 && !chipEnableN)
		else $error("start strobe outside a type 2 burst");
	a_last_final: assert property (@(posedge clk) disable iff (rst)
		!burstPinN && st.interface_type == cs_dev_pkg::TYPE_BURST2 |-> st.beats == cs_dev_pkg::SINGLE_BEAT
			&& st.cfg[cs_dev_pkg::CFG_BURST_TYPE])
		else $error("last-beat timing on a non-final beat");
	a_inhibit_single: assert property (@(posedge clk) disable iff (rst)
		burstInhibit |-> st.beats == cs_dev_pkg::SINGLE_BEAT)
		else $error("inhibited burst not reduced to one word");
	a_type2_ack: assert property (@(posedge clk) disable iff (rst)
		st.interface_type == cs_dev_pkg::TYPE_BURST2 && st.state != cs_dev_pkg::ST_IDLE |-> st.ackInternal)
		else $error("type 2 burst without internal acknowledge");
	a_ce_held_wait: assert property (@(posedge clk) disable iff (rst)
		st.state == cs_dev_pkg::ST_WAIT && clkEn |=> !chipEnableN || !bootRegionSelectN)
		else $error("chip enable dropped during wait states");
	a_port16_report: assert property (@(posedge clk) disable iff (rst)
		port16Indicate |-> st.port16 && st.beats == cs_dev_pkg::SINGLE_BEAT)
		else $error("16-bit width reported wrongly");

	c_burst_read: cover property (@(posedge clk) disable iff (rst)
		ackCount == cs_dev_pkg::BURST_BEATS && !outputEnableN);
	c_type2_burst: cover property (@(posedge clk) disable iff (rst) !startStrobeN);
	c_early_overlap: cover property (@(posedge clk) disable iff (rst)
		st.state == cs_dev_pkg::ST_DATA && overlapOk && transferStart && beatDone && lastBeat);
	c_inhibit: cover property (@(posedge clk) disable iff (rst) burstInhibit);
endmodule : chip_select_device_interface
`default_nettype wire

// File: sim/ext_mem_model.sv
// Behavioural external memory that answers beats itself when the acknowledge is external.
`timescale 1ns/1ps
`default_nettype none
module ext_mem_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic chipEnableN,
	input wire logic outputEnableN,
	input wire logic writeEnableN,
	input wire logic burstPinN,
	input wire logic [2:0] latency,
	output logic externalAck,
	output logic dataDriven
);
	logic [2:0] waited;
	always @(posedge clk) begin
		if (rst || chipEnableN) begin
			waited <= 3'h0;
			externalAck <= 1'b0;
		end else begin
			waited <= (waited == 3'h7) ? waited : waited + 3'h1;
			externalAck <= !externalAck && (waited >= latency) && !(outputEnableN && writeEnableN);
		end
	end
	// Data floats one clock after chip enable or OE is negated or the burst pin goes low, so no stale value is mistaken for data.
	always @(posedge clk) begin
		dataDriven <= !rst && !chipEnableN && !outputEnableN && burstPinN;
	end
endmodule : ext_mem_model
`default_nettype wire

// File: sim/chip_select_device_interface_tb.sv
// Self-checking testbench of the chip-select device interface.
`timescale 1ns/1ps
`default_nettype none
module chip_select_device_interface_tb;
	logic clk = 1'b0, rst = 1'b1, transferStart = 1'b0, accessWrite = 1'b0, accessBurst = 1'b0;
	logic regionHit = 1'b0, bootHit = 1'b0, internalAckSelect = 1'b1, regionPort16 = 1'b0;
	logic [3:0] interfaceType = 4'h3;
	logic [2:0] regionWaitStates = 3'h0, latency = 3'h2;
	logic [8:0] resetConfig = 9'h0DE;
	logic externalAck, dataDriven, chipEnableN, outputEnableN, writeEnableN, burstPinN, startStrobeN;
	logic bootRegionSelectN, transferAcknowledge, burstInhibit, port16Indicate, chipSelectPinMode, burstPinSelect;
	logic [31:0] bootRegionBase;
	int n_mismatch = 0, num_checks = 0;
	int ceFirst, oeFirst, ackFirst, ackLast, ackCnt, weCnt, bpCnt, bpFirst, ssFirst;
	logic inhSeen, p16Seen;
	always #50 clk = ~clk;
	chip_select_device_interface i_dut (.clk(clk), .rst(rst), .clkEn(1'b1), .resetConfig(resetConfig),
		.transferStart(transferStart), .accessWrite(accessWrite), .accessBurst(accessBurst), .regionHit(regionHit),
		.bootHit(bootHit), .interfaceType(interfaceType), .internalAckSelect(internalAckSelect),
		.regionWaitStates(regionWaitStates), .regionPort16(regionPort16), .externalAck(externalAck),
		.earlyTerminate(1'b0), .burstEnd(1'b0), .chipEnableN(chipEnableN), .outputEnableN(outputEnableN),
		.writeEnableN(writeEnableN), .burstPinN(burstPinN), .startStrobeN(startStrobeN),
		.bootRegionSelectN(bootRegionSelectN), .transferAcknowledge(transferAcknowledge),
		.burstInhibit(burstInhibit), .port16Indicate(port16Indicate), .chipSelectPinMode(chipSelectPinMode),
		.burstPinSelect(burstPinSelect), .bootRegionBase(bootRegionBase));
	ext_mem_model i_mem (.clk(clk), .rst(rst), .chipEnableN(chipEnableN), .outputEnableN(outputEnableN),
		.writeEnableN(writeEnableN), .burstPinN(burstPinN), .latency(latency), .externalAck(externalAck),
		.dataDriven(dataDriven));
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask : close_out
	task automatic chk_bit(input logic got, input logic exp, input string what);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %b want %b", $time, what, got, exp);
		end
	endtask : chk_bit
	task automatic chk_num(input int got, input int exp, input string what);
		num_checks++;
		if (got != exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %0d want %0d", $time, what, got, exp);
		end
	endtask : chk_num
	// Issues one request and records when enable, OE, start strobe, burst pin and acknowledge first moved, counted in cycles after the taking edge.
	task automatic run_access(input logic [3:0] t, input logic w, input logic b, input logic boot, input logic ia,
		input logic p16, input logic [2:0] ws);
		int k;
		logic done;
		done = 1'b0;
		{ceFirst, oeFirst, ackFirst, ackLast, bpFirst, ssFirst} = {6{32'd0}};
		{ackCnt, weCnt, bpCnt} = {3{32'd0}};
		{inhSeen, p16Seen} = 2'b00;
		@(negedge clk);
		interfaceType = t;
		accessWrite = w;
		accessBurst = b;
		regionHit = !boot;
		bootHit = boot;
		internalAckSelect = ia;
		regionPort16 = p16;
		regionWaitStates = ws;
		transferStart = 1'b1;
		for (k = 1; k <= 40 && !done; k++) begin
			@(negedge clk);
			transferStart = 1'b0;
			if (ceFirst == 0 && !(chipEnableN && bootRegionSelectN)) ceFirst = k;
			if (oeFirst == 0 && outputEnableN === 1'b0) oeFirst = k;
			if (ssFirst == 0 && startStrobeN === 1'b0) ssFirst = k;
			if (bpFirst == 0 && burstPinN === 1'b0) bpFirst = k;
			// With an external acknowledge the beat is closed by the memory itself, not by the block.
			if (transferAcknowledge === 1'b1 || (!ia && externalAck === 1'b1)) begin
				ackCnt++;
				ackLast = k;
				if (ackFirst == 0) ackFirst = k;
			end
			weCnt += (writeEnableN === 1'b0);
			bpCnt += (burstPinN === 1'b0);
			inhSeen |= (burstInhibit === 1'b1);
			p16Seen |= (port16Indicate === 1'b1);
			if (ceFirst != 0 && chipEnableN === 1'b1 && bootRegionSelectN === 1'b1) done = 1'b1;
		end
		if (!done) begin
			n_mismatch++;
			$display("[ERR] %0t access never completed", $time);
			close_out();
		end
		repeat (2) @(negedge clk);
	endtask : run_access
	task automatic t_reset();
		repeat (10) @(negedge clk);
		chk_bit(chipEnableN & bootRegionSelectN & outputEnableN & writeEnableN, 1'b1, "selects in reset");
		repeat (6) @(negedge clk);
		rst = 1'b0;
		repeat (3) @(negedge clk);
		chk_bit(chipSelectPinMode, 1'b0, "pin mode");
		chk_bit(burstPinSelect, 1'b1, "burst pin select");
		chk_bit(bootRegionBase === 32'hFFF00000, 1'b1, "boot base");
		$display("test reset done");
	endtask : t_reset
	task automatic t_sync_read();
		run_access(4'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
		chk_num(ceFirst, 1, "type 3 enable");
		chk_num(oeFirst, 2, "type 3 output enable");
		chk_num(ackCnt, 1, "type 3 acks");
		$display("test sync read done");
	endtask : t_sync_read
	task automatic t_ext_ack();
		run_access(4'h3, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 3'h0);
		chk_bit(ackFirst > 3, 1'b1, "external ack wait");
		chk_num(ackCnt, 1, "external acks");
		$display("test external ack done");
	endtask : t_ext_ack
	task automatic t_burst1();
		run_access(4'h7, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0);
		chk_num(ackCnt, 4, "type 1 burst acks");
		chk_num(weCnt, 4, "type 1 burst write beats");
		chk_bit(bpCnt > 0, 1'b1, "beat request");
		run_access(4'h5, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 3'h0);
		chk_num(weCnt, 1, "single word write");
		$display("test type 1 burst done");
	endtask : t_burst1
	task automatic t_burst2();
		run_access(4'h8, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 3'h0);
		chk_num(ssFirst, ceFirst, "start strobe");
		chk_num(ackCnt, 4, "type 2 internal acks");
		chk_num(bpFirst, ackLast, "last beat");
		chk_num(bpCnt, 1, "last beat width");
		$display("test type 2 burst done");
	endtask : t_burst2
	task automatic t_small_cases();
		run_access(4'h3, 1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 3'h0);
		chk_bit(inhSeen, 1'b1, "burst inhibit");
		chk_num(ackCnt, 1, "inhibited burst beats");
		run_access(4'h3, 1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 3'h0);
		chk_bit(p16Seen, 1'b1, "16-bit port report");
		chk_num(ackCnt, 1, "16-bit single beats");
		$display("test small cases done");
	endtask : t_small_cases
	task automatic t_boot();
		run_access(4'h1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 3'h0);
		chk_num(weCnt, 0, "boot write enable");
		chk_num(ackFirst, 5, "boot wait states");
		$display("test boot done");
	endtask : t_boot
	initial begin
		t_reset();
		t_sync_read();
		t_ext_ack();
		t_burst1();
		t_burst2();
		t_small_cases();
		t_boot();
		close_out();
	end
endmodule : chip_select_device_interface_tb
`default_nettype wire
